/* File: hdl/ssfe_pkg.sv */
// shared constants and types of the presence-detect serial slave front end
// assumes a 100 MHz system clock and the serial clock pin as a second domain
package ssfe_pkg;

	// system clock rate in kHz, so that ms * kHz gives cycles
	localparam int CLK_FREQ_KHZ = 100_000;

	// clock-low timeout window, in ms as specified
	localparam int CLOCK_LOW_TIMEOUT_MIN_MS = 25;
	localparam int CLOCK_LOW_TIMEOUT_MAX_MS = 35;
	// least time rounds up, longest rounds down; whole ms give exact counts
	localparam int CLOCK_LOW_TIMEOUT_MIN_CYC = CLOCK_LOW_TIMEOUT_MIN_MS * CLK_FREQ_KHZ;
	localparam int CLOCK_LOW_TIMEOUT_MAX_CYC = CLOCK_LOW_TIMEOUT_MAX_MS * CLK_FREQ_KHZ;

	// device type field values
	localparam logic [3:0] DEVICE_TYPE_MEM = 4'hA;
	localparam logic [3:0] DEVICE_TYPE_PROT = 4'h6;

	// protection and page command codes, select bits 3..1 plus direction bit
	localparam logic [3:0] CODE_SET_PROT0 = 4'h2;
	localparam logic [3:0] CODE_SET_PROT1 = 4'h8;
	localparam logic [3:0] CODE_SET_PROT2 = 4'hA;
	localparam logic [3:0] CODE_SET_PROT3 = 4'h0;
	localparam logic [3:0] CODE_CLEAR_PROT = 4'h6;
	localparam logic [3:0] CODE_READ_PROT0 = 4'h3;
	localparam logic [3:0] CODE_READ_PROT1 = 4'h9;
	localparam logic [3:0] CODE_READ_PROT2 = 4'hB;
	localparam logic [3:0] CODE_READ_PROT3 = 4'h1;
	localparam logic [3:0] CODE_SET_PAGE0 = 4'hC;
	localparam logic [3:0] CODE_SET_PAGE1 = 4'hE;
	localparam logic [3:0] CODE_READ_PAGE = 4'hD;

	// bits in a byte, and the count after which the ack slot follows
	localparam logic [3:0] BYTE_BITS = 4'h8;

	// reset level of synchronised bus lines (released bus reads high)
	localparam logic BUS_IDLE_LEVEL = 1'b1;

	// command kinds reported with a decoded select code
	typedef enum logic [2:0] {
		KIND_MEM = 3'h0,
		KIND_PROT_SET = 3'h1,
		KIND_PROT_CLEAR = 3'h2,
		KIND_PROT_READ = 3'h3,
		KIND_PAGE_SET = 3'h4,
		KIND_PAGE_READ = 3'h5,
		KIND_NONE = 3'h7
	} ssfe_kind_t;

	// bus sequencer states
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_ADDR = 6'h02,
		ST_ACK = 6'h04,
		ST_WRITE = 6'h08,
		ST_READ = 6'h10,
		ST_MACK = 6'h20
	} ssfe_state_e_t;

	// decoded select code, one-cycle valid
	typedef struct packed {
		logic valid;
		ssfe_kind_t kind;
		logic [1:0] index;
		logic readNotWrite;
	} ssfe_cmd_t;

	// received data byte, one-cycle valid
	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} ssfe_rx_t;

	// link-domain state: bits shifted in at serial clock rises
	typedef struct packed {
		logic [7:0] bits;
	} ssfe_link_t;

	// width of the clock-low counter
	localparam int TIMEOUT_CNT_W = 32;

	// whole state of the front end in the system clock domain
	typedef struct packed {
		logic sclS1;
		logic sclS2;
		logic sclS3;
		logic sdaS1;
		logic sdaS2;
		logic sdaS3;
		logic [2:0] strapS1;
		logic [2:0] strapS2;
		logic hvS1;
		logic hvS2;
		ssfe_state_e_t state;
		logic [3:0] bitCnt;
		logic rw;
		logic ackOn;
		logic masterAck;
		logic [7:0] txShift;
		logic [TIMEOUT_CNT_W-1:0] lowCnt;
		logic sdaLevel;
		logic sdaOe;
		ssfe_cmd_t cmd;
		ssfe_rx_t rx;
		logic txTake;
		logic stopSeen;
		logic timeoutAbort;
	} ssfe_state_t;

endpackage

/* File: hdl/ssfe_link_capture.sv */
// serial-clock domain capture of the data line
// assumes sclClk is the serial clock pin; it may stop between frames
`timescale 1ns/1ns
module ssfe_link_capture
	import ssfe_pkg::*;
(
	input wire logic sclClk,
	input wire logic sdaIn,
	output ssfe_pkg::ssfe_link_t link
);
	import ssfe_pkg::*;

	ssfe_link_t s_r; // shift register state
	ssfe_link_t s_nxt; // next shift value

	// shift the data line in at each serial clock rise
	always_comb begin
		s_nxt = s_r;
		s_nxt.bits = {s_r.bits[6:0], sdaIn};
	end

	// pure data path, no reset; the reader only looks after a rise
	always_ff @(posedge sclClk) begin
		s_r <= s_nxt;
	end

	assign link = s_r;
endmodule

/* File: hdl/ssfe_front_end.sv */
// two-wire slave front end: select decode, ack, byte transfer, timeout
// assumes a 100 MHz clk, the serial clock pin on sclClk, an open-drain pad
// with pull-up on the data line and pull-downs on the strap pins
//
// Notes on behaviour
// - memory access responds only when select bits match straps; protection and page commands ignore the straps
// - open strap pin compares as low
// - protect set/clear need high voltage detected
// - data line only pulled low or released
// - bits taken only at serial clock edges
// - long clock low abandons transfer, releases line
// - memory select code is type field plus straps
// - no select ack during nonvolatile write
`timescale 1ns/1ns
module ssfe_front_end
	import ssfe_pkg::*;
#(
	parameter int TimeoutCycles = CLOCK_LOW_TIMEOUT_MIN_CYC
)(
	input wire logic clk,
	input wire logic reset,
	input wire logic sclClk,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	input wire logic selectStrapBit0,
	input wire logic selectStrapBit1,
	input wire logic selectStrapBit2,
	input wire logic highVoltageLevel,
	input wire logic writeBusy,
	input wire logic [7:0] txByte,
	output ssfe_pkg::ssfe_cmd_t cmd,
	output ssfe_pkg::ssfe_rx_t rx,
	output logic txTake,
	output logic stopSeen,
	output logic timeoutAbort
);
	import ssfe_pkg::*;

	// refuse timeouts the counter cannot serve or that exceed the window
	if (TimeoutCycles < 1 || TimeoutCycles > CLOCK_LOW_TIMEOUT_MAX_CYC) begin : gBadTimeout
		$error("TimeoutCycles out of range");
	end

	localparam logic [TIMEOUT_CNT_W-1:0] TIMEOUT_LAST = TIMEOUT_CNT_W'(TimeoutCycles - 1);

	// reset value of the whole state
	localparam ssfe_state_t STATE_RESET = '{
		sclS1: BUS_IDLE_LEVEL, sclS2: BUS_IDLE_LEVEL, sclS3: BUS_IDLE_LEVEL,
		sdaS1: BUS_IDLE_LEVEL, sdaS2: BUS_IDLE_LEVEL, sdaS3: BUS_IDLE_LEVEL,
		strapS1: 3'h0, strapS2: 3'h0, hvS1: 1'b0, hvS2: 1'b0,
		state: ST_IDLE, bitCnt: 4'h0, rw: 1'b0, ackOn: 1'b0, masterAck: 1'b0,
		txShift: 8'h00, lowCnt: '0, sdaLevel: 1'b0, sdaOe: 1'b0,
		cmd: '{valid: 1'b0, kind: KIND_NONE, index: 2'h0, readNotWrite: 1'b0},
		rx: '{valid: 1'b0, data: 8'h00},
		txTake: 1'b0, stopSeen: 1'b0, timeoutAbort: 1'b0
	};

	ssfe_state_t s_r; // registered state
	ssfe_state_t s_nxt; // next state
	ssfe_link_t link; // bits caught on the serial clock

	// serial-clock domain shift register
	ssfe_link_capture uLink (
		.sclClk(sclClk),
		.sdaIn(sdaIn),
		.link(link)
	);

	// decode a select byte against straps and high-voltage detect
	function automatic ssfe_cmd_t decodeSelect(
		input logic [7:0] code,
		input logic [2:0] strap,
		input logic hv
	);
		ssfe_cmd_t c;
		c.valid = 1'b0;
		c.kind = KIND_NONE;
		c.index = 2'h0;
		c.readNotWrite = code[0];
		if (code[7:4] == DEVICE_TYPE_MEM) begin
			// memory access: select bits must equal the straps
			c.kind = KIND_MEM;
			c.valid = (code[3:1] == strap);
		end else if (code[7:4] == DEVICE_TYPE_PROT) begin
			// protection and page commands ignore the straps
			unique case (code[3:0])
				CODE_SET_PROT0, CODE_SET_PROT1, CODE_SET_PROT2, CODE_SET_PROT3: begin
					c.kind = KIND_PROT_SET;
					c.valid = hv;
				end
				CODE_CLEAR_PROT: begin
					c.kind = KIND_PROT_CLEAR;
					c.valid = hv;
				end
				CODE_READ_PROT0, CODE_READ_PROT1, CODE_READ_PROT2, CODE_READ_PROT3: begin
					c.kind = KIND_PROT_READ;
					c.valid = 1'b1;
				end
				CODE_SET_PAGE0, CODE_SET_PAGE1: begin
					c.kind = KIND_PAGE_SET;
					c.valid = 1'b1;
				end
				CODE_READ_PAGE: begin
					c.kind = KIND_PAGE_READ;
					c.valid = 1'b1;
				end
				default: begin
					c.valid = 1'b0; // unused codes are not acknowledged
				end
			endcase
			// block number from the printed code order
			unique case (code[3:1])
				3'h1: c.index = 2'h0;
				3'h4: c.index = 2'h1;
				3'h5: c.index = 2'h2;
				3'h0: c.index = 2'h3;
				3'h7: c.index = 2'h1; // page 1
				default: c.index = 2'h0; // page 0, clear-all
			endcase
		end
		return c;
	endfunction

	// next-state logic of the whole front end
	always_comb begin
		logic sclRise;
		logic sclFall;
		logic startCond;
		logic stopCond;
		logic timedOut;
		ssfe_cmd_t dec;
		sclRise = 1'b0;
		sclFall = 1'b0;
		startCond = 1'b0;
		stopCond = 1'b0;
		timedOut = 1'b0;
		dec = '0;

		s_nxt = s_r;
		// two-flop synchronisers; stage 1 feeds stage 2 only
		s_nxt.sclS1 = sclClk;
		s_nxt.sclS2 = s_r.sclS1;
		s_nxt.sclS3 = s_r.sclS2;
		s_nxt.sdaS1 = sdaIn;
		s_nxt.sdaS2 = s_r.sdaS1;
		s_nxt.sdaS3 = s_r.sdaS2;
		// open strap pins arrive low through the pad pull-downs
		s_nxt.strapS1 = {selectStrapBit2, selectStrapBit1, selectStrapBit0};
		s_nxt.strapS2 = s_r.strapS1;
		s_nxt.hvS1 = highVoltageLevel;
		s_nxt.hvS2 = s_r.hvS1;
		// pulses default low
		s_nxt.cmd.valid = 1'b0;
		s_nxt.rx.valid = 1'b0;
		s_nxt.txTake = 1'b0;
		s_nxt.stopSeen = 1'b0;
		s_nxt.timeoutAbort = 1'b0;
		// the line is never driven high
		s_nxt.sdaLevel = 1'b0;

		// edges of the serial clock and bus conditions
		sclRise = s_r.sclS2 & ~s_r.sclS3;
		sclFall = ~s_r.sclS2 & s_r.sclS3;
		startCond = s_r.sclS2 & s_r.sclS3 & s_r.sdaS3 & ~s_r.sdaS2;
		stopCond = s_r.sclS2 & s_r.sclS3 & ~s_r.sdaS3 & s_r.sdaS2;

		// clock-low timer, held once it reaches the limit
		if (s_r.sclS2) begin
			s_nxt.lowCnt = '0;
		end else if (s_r.lowCnt != TIMEOUT_LAST) begin
			s_nxt.lowCnt = s_r.lowCnt + 1'b1;
		end else begin
			timedOut = 1'b1;
		end

		dec = decodeSelect(link.bits, s_r.strapS2, s_r.hvS2);

		unique case (s_r.state)
			ST_IDLE: begin
				// standby, line released, only a start leaves
				s_nxt.sdaOe = 1'b0;
			end
			ST_ADDR: begin
				// gather the select code
				if (sclRise) begin
					s_nxt.bitCnt = s_r.bitCnt + 1'b1;
					if (s_r.bitCnt == BYTE_BITS - 4'h1) begin
						s_nxt.rw = link.bits[0];
						s_nxt.cmd = dec;
						s_nxt.cmd.valid = dec.valid & ~writeBusy;
						s_nxt.state = (dec.valid && !writeBusy) ? ST_ACK : ST_IDLE;
						s_nxt.ackOn = 1'b0;
					end
				end
			end
			ST_ACK: begin
				// drive ack through the ninth clock
				if (sclFall && !s_r.ackOn) begin
					s_nxt.ackOn = 1'b1;
					s_nxt.sdaOe = 1'b1;
				end else if (sclFall) begin
					s_nxt.ackOn = 1'b0;
					s_nxt.bitCnt = 4'h0;
					if (s_r.rw) begin
						// read: first data bit goes out on this fall
						s_nxt.state = ST_READ;
						s_nxt.txShift = txByte;
						s_nxt.txTake = 1'b1;
						s_nxt.sdaOe = ~txByte[7];
					end else begin
						s_nxt.state = ST_WRITE;
						s_nxt.sdaOe = 1'b0;
					end
				end
			end
			ST_WRITE: begin
				// receive a data byte, then ack it
				if (sclRise) begin
					s_nxt.bitCnt = s_r.bitCnt + 1'b1;
					if (s_r.bitCnt == BYTE_BITS - 4'h1) begin
						s_nxt.rx.valid = 1'b1;
						s_nxt.rx.data = link.bits;
						s_nxt.state = ST_ACK;
					end
				end
			end
			ST_READ: begin
				// shift a byte out, msb first, on each fall
				if (sclRise) begin
					s_nxt.bitCnt = s_r.bitCnt + 1'b1;
				end else if (sclFall) begin
					if (s_r.bitCnt == BYTE_BITS) begin
						s_nxt.sdaOe = 1'b0;
						s_nxt.bitCnt = 4'h0;
						s_nxt.state = ST_MACK;
					end else begin
						s_nxt.sdaOe = ~s_r.txShift[3'(4'h7 - s_r.bitCnt)];
					end
				end
			end
			ST_MACK: begin
				// sample the master's ack, then continue or stand by
				if (sclRise) begin
					s_nxt.bitCnt = 4'h1;
					s_nxt.masterAck = ~link.bits[0];
				end else if (sclFall && s_r.bitCnt == 4'h1) begin
					s_nxt.bitCnt = 4'h0;
					if (s_r.masterAck) begin
						s_nxt.state = ST_READ;
						s_nxt.txShift = txByte;
						s_nxt.txTake = 1'b1;
						s_nxt.sdaOe = ~txByte[7];
					end else begin
						s_nxt.state = ST_IDLE;
					end
				end
			end
		endcase

		// stop ends any transfer and releases the line
		if (stopCond) begin
			s_nxt.stopSeen = 1'b1;
			s_nxt.state = ST_IDLE;
			s_nxt.sdaOe = 1'b0;
		end
		// start or repeated start begins a new select code
		if (startCond) begin
			s_nxt.state = ST_ADDR;
			s_nxt.bitCnt = 4'h0;
			s_nxt.sdaOe = 1'b0;
		end
		// clock held low too long: abandon, release, wait for a start
		if (timedOut && s_r.state != ST_IDLE) begin
			s_nxt.timeoutAbort = 1'b1;
			s_nxt.state = ST_IDLE;
			s_nxt.sdaOe = 1'b0;
		end
	end

	// state register, synchronous reset
	always_ff @(posedge clk) begin
		if (reset) begin
			s_r <= STATE_RESET;
		end else begin
			s_r <= s_nxt;
		end
	end

	// outputs straight from the state register
	assign sdaOut = s_r.sdaLevel;
	assign sdaOe = s_r.sdaOe;
	assign cmd = s_r.cmd;
	assign rx = s_r.rx;
	assign txTake = s_r.txTake;
	assign stopSeen = s_r.stopSeen;
	assign timeoutAbort = s_r.timeoutAbort;
endmodule

/* File: dv/ssfe_monitor.sv */
// checker of the front end: ack, decode, edges and clock-low timeout
// assumes clk is the system clock and sclClk the raw serial clock pin
`timescale 1ns/1ns
module ssfe_monitor
	import ssfe_pkg::*;
#(
	parameter int TimeoutCycles = 200
)(
	input wire logic clk,
	input wire logic reset,
	input wire logic sclClk,
	input wire logic sdaIn,
	input wire logic sdaOut,
	input wire logic sdaOe,
	input wire logic selectStrapBit0,
	input wire logic selectStrapBit1,
	input wire logic selectStrapBit2,
	input wire logic highVoltageLevel,
	input wire logic writeBusy,
	input ssfe_pkg::ssfe_cmd_t cmd,
	input wire logic stopSeen,
	input wire logic timeoutAbort
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	logic [2:0] sclSync_r; // serial clock seen in clk domain
	logic [7:0] addrSh_r; // bits taken at seen clock rises
	logic [31:0] lowCnt_r; // cycles with raw clock low
	logic memCmd; // decoded memory select code
	assign memCmd = cmd.valid && cmd.kind == KIND_MEM;
	// follow the clock, shift data at each rise, count low time
	always_ff @(posedge clk) begin
		sclSync_r <= {sclSync_r[1:0], sclClk};
		if (sclSync_r[1] && !sclSync_r[2]) begin
			addrSh_r <= {addrSh_r[6:0], sdaIn};
		end
		lowCnt_r <= (reset || sclClk) ? 32'h0 : lowCnt_r + 32'h1;
	end
	// ack pulled after a decoded select code
	sequence ackRise_s;
		##[1:150] $rose(sdaOe);
	endsequence
	// line stays released and nothing decoded
	sequence quiet_s;
		(!sdaOe && !cmd.valid)[*8];
	endsequence
	drive_low_a: assert property (sdaOut == 1'b0)
		else $error("data line driven high");
	edge_gate_a: assert property ($changed(sdaOe) |-> !sclClk)
		else $error("data line changed with clock high");
	sel_match_a: assert property (memCmd |-> addrSh_r[3:1] == {selectStrapBit2,
		selectStrapBit1, selectStrapBit0})
		else $error("select bits differ from straps");
	type_field_a: assert property (memCmd |-> addrSh_r[7:4] == DEVICE_TYPE_MEM)
		else $error("memory kind with wrong type field");
	hv_gate_a: assert property (cmd.valid && cmd.kind inside {KIND_PROT_SET,
		KIND_PROT_CLEAR} |-> highVoltageLevel)
		else $error("protect command without high voltage");
	busy_hold_a: assert property (cmd.valid |-> !writeBusy)
		else $error("select decoded while write busy");
	ack_follow_a: assert property (cmd.valid |-> ackRise_s)
		else $error("no ack after select code");
	timeout_win_a: assert property (timeoutAbort |-> lowCnt_r >= TimeoutCycles
		&& lowCnt_r <= TimeoutCycles + 6)
		else $error("abort at wrong clock-low time");
	abort_idle_a: assert property (timeoutAbort |-> ##1 quiet_s)
		else $error("activity right after abort");
	stop_high_a: assert property (stopSeen |-> sclClk)
		else $error("stop seen with clock low");
endmodule
bind ssfe_front_end ssfe_monitor #(.TimeoutCycles(TimeoutCycles)) i_monitor (
	.clk(clk), .reset(reset), .sclClk(sclClk), .sdaIn(sdaIn), .sdaOut(sdaOut),
	.sdaOe(sdaOe), .selectStrapBit0(selectStrapBit0), .selectStrapBit1(selectStrapBit1),
	.selectStrapBit2(selectStrapBit2), .highVoltageLevel(highVoltageLevel),
	.writeBusy(writeBusy), .cmd(cmd), .stopSeen(stopSeen), .timeoutAbort(timeoutAbort));

/* File: dv/ssfe_bus_master.sv */
// two-wire bus master model on its own link clock
// assumes the bench resolves the open-drain data wire with a pull-up
`timescale 1ns/1ns
module ssfe_bus_master (
	input wire logic mclk,
	input wire logic sda,
	output logic scl,
	output logic sdaPull
);
	// idle bus: clock high and still, data released
	initial begin
		scl = 1'b1;
		sdaPull = 1'b0;
	end
	// half bit of 50 link ticks, slow enough for the syncs
	task automatic half();
		repeat (50) @(posedge mclk);
	endtask
	// start: data falls with clock high
	task automatic start();
		sdaPull <= 1'b0;
		half();
		scl <= 1'b1;
		half();
		sdaPull <= 1'b1;
		half();
		scl <= 1'b0;
	endtask
	// one bit: data set well after the fall, sampled before next fall
	task automatic bitx(input logic b, output logic r);
		repeat (5) @(posedge mclk);
		sdaPull <= !b;
		half();
		scl <= 1'b1;
		half();
		r = sda;
		scl <= 1'b0;
	endtask
	// byte msb first, then the ninth bit (1 releases the line)
	task automatic xfer(input logic [7:0] d, input logic nine, output logic [7:0] q,
		output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitx(d[i], q[i]);
		end
		bitx(nine, r);
		ack = !r;
	endtask
	// stop: data rises with clock high, then idle
	task automatic stop();
		repeat (5) @(posedge mclk);
		sdaPull <= 1'b1;
		half();
		scl <= 1'b1;
		half();
		sdaPull <= 1'b0;
		half();
	endtask
endmodule

/* File: dv/tb_ssfe_front_end.sv */
// self-checking bench of the front end with a bus master model
// assumes the checker is bound to the front end from its own file
`timescale 1ns/1ns
module tb_ssfe_front_end;
	import ssfe_pkg::*;
	localparam int TimeoutCycles = 200; // shortened clock-low limit
	logic clk = 1'b0;
	logic mclk = 1'b0; // link clock, 12 ns
	logic reset = 1'b1;
	logic scl;
	logic mPull; // master pulls data low
	logic sdaOe;
	logic [2:0] strap = 3'h0; // 0 models an open pin
	logic hv = 1'b0;
	logic busy = 1'b0;
	logic [7:0] txByte = 8'h00;
	ssfe_cmd_t cmd;
	ssfe_rx_t rx;
	logic timeoutAbort;
	logic take; // byte loaded into the shifter
	logic stopP; // stop condition seen
	int nTake = 0; // load pulses so far
	int nStop = 0; // stop pulses so far
	ssfe_cmd_t lastCmd; // last decoded select code
	logic [7:0] lastRx; // last written byte
	int n_fail = 0;
	int comparisons = 0;
	wire sda = (sdaOe || mPull) ? 1'b0 : 1'b1; // pull-up
	always #5 clk = ~clk;
	always #6 mclk = ~mclk;
	ssfe_front_end #(.TimeoutCycles(TimeoutCycles)) i_dut (.clk(clk), .reset(reset),
		.sclClk(scl), .sdaIn(sda), .sdaOut(), .sdaOe(sdaOe), .selectStrapBit0(strap[0]),
		.selectStrapBit1(strap[1]), .selectStrapBit2(strap[2]), .highVoltageLevel(hv),
		.writeBusy(busy), .txByte(txByte), .cmd(cmd), .rx(rx), .txTake(take), .stopSeen(stopP),
		.timeoutAbort(timeoutAbort));
	ssfe_bus_master i_master (.mclk(mclk), .sda(sda), .scl(scl), .sdaPull(mPull));
	// keep the last decode and write byte
	always @(posedge clk) begin
		if (cmd.valid) lastCmd <= cmd;
		if (rx.valid) lastRx <= rx.data;
		// count one-cycle pulses that the scenarios look at later
		if (take === 1'b1) nTake <= nTake + 1;
		if (stopP === 1'b1) nStop <= nStop + 1;
	end
	// compare and count
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// verdict and end of run
	task automatic final_report();
		$display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// ack expected for a select byte
	function automatic logic expAck(input logic [7:0] a);
		if (a[7:4] == DEVICE_TYPE_MEM) return a[3:1] == strap;
		if (a[7:4] != DEVICE_TYPE_PROT) return 1'b0;
		if (a[3:0] inside {CODE_SET_PROT0, CODE_SET_PROT1, CODE_SET_PROT2, CODE_SET_PROT3,
			CODE_CLEAR_PROT}) return hv;
		return a[3:0] inside {CODE_READ_PROT0, CODE_READ_PROT1, CODE_READ_PROT2,
			CODE_READ_PROT3, CODE_SET_PAGE0, CODE_SET_PAGE1, CODE_READ_PAGE};
	endfunction
	// start then select byte
	task automatic frame(input logic [7:0] a, output logic ack);
		logic [7:0] q;
		i_master.start();
		i_master.xfer(a, 1'b1, q, ack);
	endtask
	initial begin
		logic ack;
		logic [7:0] a;
		logic [7:0] d;
		logic [7:0] q;
		logic [2:0] s;
		int k;
		int t0;
		int p0;
		void'($urandom(4));
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		repeat (5) @(posedge clk);
		// select match and mismatch, then a write byte
		for (int i = 0; i < 8; i++) begin
			s = 3'($urandom);
			strap <= s;
			@(posedge clk);
			a = {DEVICE_TYPE_MEM, i[0] ? s : 3'($urandom), 1'b0};
			frame(a, ack);
			check(8'(ack), 8'(expAck(a)));
			if (expAck(a)) begin
				check(8'(lastCmd.kind), 8'(KIND_MEM));
				d = 8'($urandom);
				i_master.xfer(d, 1'b1, q, ack);
				check(8'(ack), 8'h01);
				check(lastRx, d);
			end
			i_master.stop();
		end
		$display("select test done");
		// every type-6 code with and without high voltage
		for (int i = 0; i < 32; i++) begin
			hv <= i[4];
			@(posedge clk);
			a = {DEVICE_TYPE_PROT, 4'(i)};
			frame(a, ack);
			check(8'(ack), 8'(expAck(a)));
			// an acked read command drives a byte; take it and nack so stop is clean
			if (expAck(a) && a[0]) begin
				i_master.xfer(8'hFF, 1'b1, q, ack);
				check(q, txByte);
			end
			i_master.stop();
		end
		$display("command test done");
		// no ack while a write cycle runs
		busy <= 1'b1;
		@(posedge clk);
		frame({DEVICE_TYPE_MEM, strap, 1'b0}, ack);
		check(8'(ack), 8'h00);
		i_master.stop();
		busy <= 1'b0;
		// read one byte, master nacks
		d = 8'($urandom);
		txByte <= d;
		t0 = nTake;
		p0 = nStop;
		@(posedge clk);
		frame({DEVICE_TYPE_MEM, strap, 1'b1}, ack);
		check(8'(ack), 8'h01);
		i_master.xfer(8'hFF, 1'b1, q, ack);
		check(q, d);
		i_master.stop();
		check(8'(nTake - t0), 8'h01);
		check(8'(nStop - p0), 8'h01);
		$display("busy and read test done");
		// clock held low mid-read while the line is pulled: abort must release it
		txByte <= {1'b0, 7'($urandom)};
		@(posedge clk);
		frame({DEVICE_TYPE_MEM, strap, 1'b1}, ack);
		check(8'(ack), 8'h01);
		repeat (10) @(posedge clk);
		check(8'(sdaOe), 8'h01);
		k = 10;
		while (timeoutAbort !== 1'b1 && k < 400) begin
			@(posedge clk);
			k++;
		end
		check(8'(k < 400), 8'h01);
		if (k >= 400) final_report();
		check(8'(k >= TimeoutCycles), 8'h01);
		@(posedge clk);
		check(8'(sdaOe), 8'h00);
		i_master.xfer({DEVICE_TYPE_MEM, strap, 1'b0}, 1'b1, q, ack);
		check(8'(ack), 8'h00);
		i_master.stop();
		$display("timeout test done");
		final_report();
	end
endmodule
